// ==== rtl/pksl_pkg.sv ====
package pksl_pkg;
	localparam int CLK_MHZ = 20;
	localparam int CLK_KHZ = CLK_MHZ * 1000;

	// Power-on, self-test and scan timing
	localparam int POR_MS = 150;
	localparam int POR_CYC = POR_MS * CLK_KHZ;
	localparam int TEST_MS = 400;
	localparam int TEST_CYC = TEST_MS * CLK_KHZ;
	localparam int SCAN_MS = 10;
	localparam int SCAN_CYC = SCAN_MS * CLK_KHZ;

	// Link clock phases in microseconds
	localparam int T_LOW_US = 40;
	localparam int T_HIGH_US = 35;
	localparam int T_HBT_US = 20;
	localparam logic [9:0] LOW_CYC = 10'(T_LOW_US * CLK_MHZ);
	localparam logic [9:0] HIGH_CYC = 10'(T_HIGH_US * CLK_MHZ);
	localparam logic [9:0] HBT_CYC = 10'(T_HBT_US * CLK_MHZ);
	localparam logic [9:0] SYNC_SKIP = 10'h004;
	localparam logic [3:0] FRAME_LAST = 4'hA;
	localparam logic [3:0] PARITY_BIT = 4'h9;

	localparam logic [3:0] SETTLE_CYC = 4'h4;
	localparam logic [5:0] REP_DELAY_TICKS = 6'h32;
	localparam logic [5:0] REP_PERIOD_TICKS = 6'h09;

	localparam logic [7:0] CODE_DONE = 8'hAA;
	localparam logic [7:0] CODE_FAIL = 8'hFC;
	localparam logic [7:0] CODE_OVERRUN = 8'h00;
	localparam logic [7:0] CODE_BREAK_PFX = 8'hF0;
	localparam logic [7:0] CODE_BREAK_BIT = 8'h80;
	localparam logic [7:0] CODE_BASE_1 = 8'h01;
	localparam logic [7:0] CODE_BASE_2 = 8'h40;
	localparam logic [7:0] CODE_BASE_3 = 8'h41;
	localparam logic [5:0] KEY_PAUSE = 6'h3F;

	localparam logic [1:0] MODE_1 = 2'h1;
	localparam logic [1:0] MODE_2 = 2'h2;
	localparam logic [1:0] MODE_3 = 2'h3;
	localparam logic [1:0] CFG_NORMAL = 2'h0;
	localparam logic [1:0] CFG_MAKE_ONLY = 2'h1;
	localparam logic [1:0] CFG_BREAK_ONLY = 2'h2;
	localparam logic [1:0] CFG_REPEAT = 2'h3;

	localparam logic [4:0] FIFO_DEPTH = 5'h10;

	function automatic logic [7:0] keyCode(input logic [5:0] idx,
		input logic [1:0] mode);
		if (mode == MODE_1) begin
			return {2'h0, idx} + CODE_BASE_1;
		end else if (mode == MODE_3) begin
			return {2'h0, idx} + CODE_BASE_3;
		end
		return {2'h0, idx} + CODE_BASE_2;
	endfunction
endpackage

// ==== rtl/pksl_fifo_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface pksl_fifo_if;
	logic push;
	logic [7:0] pushData;
	logic pop;
	logic [7:0] popData;
	logic popValid;
	logic [4:0] count;
	modport producer(output push, output pushData, output pop,
		input popData, input popValid, input count);
	modport store(input push, input pushData, input pop,
		output popData, output popValid, output count);
endinterface // pksl_fifo_if
`default_nettype wire

// ==== rtl/pksl_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module pksl_fifo (
	input wire logic clk,
	input wire logic reset,
	pksl_fifo_if.store fif
);
	typedef struct packed {
		logic [3:0] wp;
		logic [3:0] rp;
		logic [4:0] count;
		logic [7:0] popData;
		logic popValid;
	} pksl_fifo_t;

	pksl_fifo_t s_r, s_nxt;
	logic [7:0] mem [16];
	logic doPush, doPop;

	always_comb begin
		s_nxt = s_r;
		doPush = fif.push && (s_r.count != pksl_pkg::FIFO_DEPTH);
		doPop = fif.pop && (s_r.count != 5'h00);
		s_nxt.popValid = doPop;
		if (doPush) begin
			s_nxt.wp = s_r.wp + 4'h1;
		end
		if (doPop) begin
			s_nxt.popData = mem[s_r.rp];
			s_nxt.rp = s_r.rp + 4'h1;
		end
		s_nxt.count = s_r.count + {4'h0, doPush} - {4'h0, doPop};
	end

	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[s_r.wp] <= fif.pushData;
		end
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign fif.popData = s_r.popData;
	assign fif.popValid = s_r.popValid;
	assign fif.count = s_r.count;
endmodule // pksl_fifo
`default_nettype wire

// ==== rtl/pksl_link.sv ====
`timescale 1ns/100ps
`default_nettype none
module pksl_link (
	input wire logic clk,
	input wire logic reset,
	input wire logic txGo,
	input wire logic [7:0] txByte,
	input wire logic lineClk,
	input wire logic lineDat,
	output logic txBusy,
	output logic txDone,
	output logic txAbort,
	output logic clkOe,
	output logic datOe
);
	typedef enum logic [3:0] {
		L_IDLE = 4'h1,
		L_HBT = 4'h2,
		L_HIGH = 4'h4,
		L_LOW = 4'h8
	} pksl_link_state_t;

	typedef struct packed {
		pksl_link_state_t st;
		logic [9:0] cnt;
		logic [3:0] bitIdx;
		logic [10:0] frame;
		logic busy, done, abort, clkOe, datOe;
	} pksl_link_t;

	pksl_link_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.abort = 1'b0;
		case (s_r.st)
			L_IDLE: begin
				if (txGo) begin
					// Start low, LSB first, odd parity, stop high
					s_nxt.frame = {1'b1, ~^txByte, txByte, 1'b0};
					s_nxt.bitIdx = 4'h0;
					s_nxt.cnt = pksl_pkg::HBT_CYC;
					s_nxt.busy = 1'b1;
					s_nxt.st = L_HBT;
				end
			end
			L_HBT: begin
				// Held-low line means inhibit: wait, keep the byte
				if (!lineClk || !lineDat) begin
					s_nxt.cnt = pksl_pkg::HBT_CYC;
				end else if (s_r.cnt == 10'h001) begin
					s_nxt.datOe = ~s_r.frame[0];
					s_nxt.cnt = pksl_pkg::HIGH_CYC;
					s_nxt.st = L_HIGH;
				end else begin
					s_nxt.cnt = s_r.cnt - 10'h001;
				end
			end
			L_HIGH: begin
				// Skip cycles where our own release is still in the synchroniser
				if (s_r.cnt <= pksl_pkg::HIGH_CYC - pksl_pkg::SYNC_SKIP
						&& !lineClk && s_r.bitIdx > pksl_pkg::PARITY_BIT) begin
					// Parity rising edge already passed: give up, resend later
					s_nxt.abort = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.datOe = 1'b0;
					s_nxt.st = L_IDLE;
				end else if (s_r.cnt == 10'h001) begin
					s_nxt.clkOe = 1'b1;
					s_nxt.cnt = pksl_pkg::LOW_CYC;
					s_nxt.st = L_LOW;
				end else begin
					s_nxt.cnt = s_r.cnt - 10'h001;
				end
			end
			L_LOW: begin
				if (s_r.cnt == 10'h001) begin
					s_nxt.clkOe = 1'b0;
					if (s_r.bitIdx == pksl_pkg::FRAME_LAST) begin
						s_nxt.done = 1'b1;
						s_nxt.busy = 1'b0;
						s_nxt.datOe = 1'b0;
						s_nxt.st = L_IDLE;
					end else begin
						s_nxt.bitIdx = s_r.bitIdx + 4'h1;
						s_nxt.frame = {1'b1, s_r.frame[10:1]};
						s_nxt.datOe = ~s_r.frame[1];
						s_nxt.cnt = pksl_pkg::HIGH_CYC;
						s_nxt.st = L_HIGH;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 10'h001;
				end
			end
			default: begin
				s_nxt.st = L_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.st <= L_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign txBusy = s_r.busy;
	assign txDone = s_r.done;
	assign txAbort = s_r.abort;
	assign clkOe = s_r.clkOe;
	assign datOe = s_r.datOe;
endmodule // pksl_link
`default_nettype wire

// ==== rtl/pksl_top.sv ====
// How it works
// - Key matrix is scanned every 10 ms while the link keeps running.
// - A key going down sends a press code; coming up sends a release code.
// - Pause key sends its press code only, never a release code.
// - Internal power-on reset fires 150 ms to 2 s after power-up.
// - Self-test checks for shorted keys and lasts 300 to 500 ms.
// - Failed self-test sends an error code, then idles until a host command.
// - Passed self-test sends the completion byte, then scanning starts.
// - Scan bytes wait in a 16-byte FIFO; responses and repeats bypass it.
// - Byte that will not fit becomes the overrun code; later scan data is dropped until the overrun code has been sent.
// - Multi-byte keystroke is taken only when all its bytes fit.
// - Low clock before sending means inhibit; hold the byte and send later.
// - Each device-to-host frame is eleven bits long.
// - Host halts a frame by pulling clock low; device watches the clock.
// - Frame finishes on halt only if parity clock rise has not happened.
// - Three scan code sets, chosen by user or host; set two after reset.
// - In set three each key but pause is press-and-release, press-only, release-only or repeating.
`timescale 1ns/100ps
`default_nettype none
module pksl_top #(
	parameter int POR_CYC = pksl_pkg::POR_CYC,
	parameter int TEST_CYC = pksl_pkg::TEST_CYC,
	parameter int SCAN_CYC = pksl_pkg::SCAN_CYC
) (
	input wire logic clk,
	input wire logic reset,
	output logic [7:0] colDrive,
	input wire logic [7:0] rowSense,
	input wire logic kbClkIn,
	output logic kbClkOut,
	output logic kbClkOe,
	input wire logic kbDatIn,
	output logic kbDatOut,
	output logic kbDatOe,
	input wire logic modeLoad,
	input wire logic [1:0] modeSel,
	input wire logic cfgLoad,
	input wire logic [5:0] cfgKey,
	input wire logic [1:0] cfgVal,
	input wire logic hostCmdRcvd,
	output logic [1:0] scanMode,
	output logic selfTestFail,
	output logic keysActive
);
	typedef enum logic [7:0] {
		S_POR = 8'h01,
		S_TEST = 8'h02,
		S_REPORT = 8'h04,
		S_OFF = 8'h08,
		S_IDLE = 8'h10,
		S_SETTLE = 8'h20,
		S_ROW = 8'h40,
		S_PUSH2 = 8'h80
	} pksl_scan_state_t;

	typedef enum logic [2:0] {
		T_IDLE = 3'h1,
		T_POP = 3'h2,
		T_SEND = 3'h4
	} pksl_send_state_t;

	typedef enum logic [1:0] {
		SRC_RESP = 2'h0,
		SRC_REP = 2'h1,
		SRC_OVR = 2'h2,
		SRC_FIFO = 2'h3
	} pksl_src_t;

	typedef struct packed {
		pksl_scan_state_t st;
		pksl_send_state_t ts;
		pksl_src_t src;
		logic [22:0] timer;
		logic [17:0] tick;
		logic tickPulse;
		logic [2:0] col, row;
		logic [3:0] settle;
		logic [7:0] rowMeta, rowSync, rowSnap;
		logic clkMeta, clkSync, datMeta, datSync;
		logic [63:0] keyState;
		logic [127:0] keyCfg;
		logic [1:0] mode;
		logic [7:0] colDrive;
		logic [7:0] second;
		logic push;
		logic [7:0] pushData;
		logic pop;
		logic overrun, respPend, fail, scanning;
		logic [7:0] respCode;
		logic repArmed, repPend;
		logic [5:0] repKey, repCnt;
		logic txGo;
		logic [7:0] txByte;
		logic pinLow;
	} pksl_top_t;

	pksl_top_t s_r, s_nxt;
	pksl_fifo_if fif();
	logic txBusy, txDone, txAbort;

	logic [5:0] idx;
	logic keyDown;
	logic [1:0] cfg;
	logic [1:0] need;
	logic [7:0] code, first;
	logic [5:0] effCount;
	logic adv, fits;

	pksl_fifo u_fifo (
		.clk(clk),
		.reset(reset),
		.fif(fif)
	);

	pksl_link u_link (
		.clk(clk),
		.reset(reset),
		.txGo(s_r.txGo),
		.txByte(s_r.txByte),
		.lineClk(s_r.clkSync),
		.lineDat(s_r.datSync),
		.txBusy(txBusy),
		.txDone(txDone),
		.txAbort(txAbort),
		.clkOe(kbClkOe),
		.datOe(kbDatOe)
	);

	assign fif.push = s_r.push;
	assign fif.pushData = s_r.pushData;
	assign fif.pop = s_r.pop;

	always_comb begin
		s_nxt = s_r;
		idx = {s_r.col, s_r.row};
		keyDown = ~s_r.rowSnap[s_r.row];
		cfg = pksl_pkg::CFG_NORMAL;
		need = 2'h0;
		code = pksl_pkg::keyCode(idx, s_r.mode);
		first = code;
		adv = 1'b0;
		// A push still in flight is counted as already stored
		effCount = {1'b0, fif.count} + {5'h00, s_r.push};
		fits = 1'b0;

		s_nxt.push = 1'b0;
		s_nxt.pop = 1'b0;
		s_nxt.rowMeta = rowSense;
		s_nxt.rowSync = s_r.rowMeta;
		s_nxt.clkMeta = kbClkIn;
		s_nxt.clkSync = s_r.clkMeta;
		s_nxt.datMeta = kbDatIn;
		s_nxt.datSync = s_r.datMeta;

		// 10 ms scan enable
		s_nxt.tickPulse = 1'b0;
		if (s_r.tick == 18'h00000) begin
			s_nxt.tick = 18'(SCAN_CYC - 1);
			s_nxt.tickPulse = 1'b1;
		end else begin
			s_nxt.tick = s_r.tick - 18'h00001;
		end

		if (modeLoad && modeSel != 2'h0) begin
			s_nxt.mode = modeSel;
		end
		if (cfgLoad) begin
			s_nxt.keyCfg[{cfgKey, 1'b0} +: 2] = cfgVal;
		end

		// Sender: responses first, then repeats, then buffered bytes
		case (s_r.ts)
			T_IDLE: begin
				if (s_r.respPend) begin
					s_nxt.txByte = s_r.respCode;
					s_nxt.src = SRC_RESP;
					s_nxt.txGo = 1'b1;
					s_nxt.ts = T_SEND;
				end else if (s_r.repPend) begin
					s_nxt.txByte = pksl_pkg::keyCode(s_r.repKey, s_r.mode);
					s_nxt.src = SRC_REP;
					s_nxt.txGo = 1'b1;
					s_nxt.ts = T_SEND;
				end else if (fif.count != 5'h00) begin
					s_nxt.pop = 1'b1;
					s_nxt.ts = T_POP;
				end else if (s_r.overrun && !s_r.push) begin
					// Overrun code goes out where the lost byte would have
					s_nxt.txByte = pksl_pkg::CODE_OVERRUN;
					s_nxt.src = SRC_OVR;
					s_nxt.txGo = 1'b1;
					s_nxt.ts = T_SEND;
				end
			end
			T_POP: begin
				if (fif.popValid) begin
					s_nxt.txByte = fif.popData;
					s_nxt.src = SRC_FIFO;
					s_nxt.txGo = 1'b1;
					s_nxt.ts = T_SEND;
				end
			end
			T_SEND: begin
				if (txBusy) begin
					s_nxt.txGo = 1'b0;
				end
				if (txAbort) begin
					s_nxt.txGo = 1'b1;
				end else if (txDone) begin
					s_nxt.ts = T_IDLE;
					if (s_r.src == SRC_RESP) begin
						s_nxt.respPend = 1'b0;
					end else if (s_r.src == SRC_REP) begin
						s_nxt.repPend = 1'b0;
					end else if (s_r.src == SRC_OVR) begin
						s_nxt.overrun = 1'b0;
					end
				end
			end
			default: begin
				s_nxt.ts = T_IDLE;
			end
		endcase

		case (s_r.st)
			S_POR: begin
				if (s_r.timer == 23'h000000) begin
					s_nxt.st = S_TEST;
					s_nxt.timer = 23'(TEST_CYC - 1);
					s_nxt.colDrive = 8'h00;
				end else begin
					s_nxt.timer = s_r.timer - 23'h000001;
				end
			end
			S_TEST: begin
				// All columns driven: any row low now is a shorted key
				if (s_r.timer == 23'h000000) begin
					s_nxt.fail = ~&s_r.rowSync;
					s_nxt.respCode = (~&s_r.rowSync) ? pksl_pkg::CODE_FAIL
						: pksl_pkg::CODE_DONE;
					s_nxt.respPend = 1'b1;
					s_nxt.colDrive = 8'hFF;
					s_nxt.keyState = 64'h0;
					s_nxt.st = S_REPORT;
				end else begin
					s_nxt.timer = s_r.timer - 23'h000001;
				end
			end
			S_REPORT: begin
				if (!s_r.respPend) begin
					s_nxt.st = s_r.fail ? S_OFF : S_IDLE;
					s_nxt.scanning = ~s_r.fail;
				end
			end
			S_OFF: begin
				if (hostCmdRcvd) begin
					s_nxt.st = S_IDLE;
					s_nxt.fail = 1'b0;
					s_nxt.scanning = 1'b1;
				end
			end
			S_IDLE: begin
				if (s_r.tickPulse) begin
					s_nxt.col = 3'h0;
					s_nxt.colDrive = 8'hFE;
					s_nxt.settle = pksl_pkg::SETTLE_CYC;
					s_nxt.st = S_SETTLE;
				end
			end
			S_SETTLE: begin
				// Covers pin delay plus the two synchroniser stages
				if (s_r.settle == 4'h0) begin
					s_nxt.rowSnap = s_r.rowSync;
					s_nxt.row = 3'h0;
					s_nxt.st = S_ROW;
				end else begin
					s_nxt.settle = s_r.settle - 4'h1;
				end
			end
			S_ROW: begin
				adv = 1'b1;
				if (s_r.mode == pksl_pkg::MODE_3) begin
					cfg = s_r.keyCfg[{idx, 1'b0} +: 2];
				end
				if (keyDown) begin
					if (cfg != pksl_pkg::CFG_BREAK_ONLY) begin
						need = 2'h1;
					end
				end else if (idx == pksl_pkg::KEY_PAUSE) begin
					need = 2'h0;
				end else if (s_r.mode == pksl_pkg::MODE_1) begin
					need = 2'h1;
					first = code | pksl_pkg::CODE_BREAK_BIT;
				end else if (cfg != pksl_pkg::CFG_MAKE_ONLY) begin
					need = 2'h2;
					first = pksl_pkg::CODE_BREAK_PFX;
				end
				fits = (effCount + {4'h0, need}) <= {1'b0, pksl_pkg::FIFO_DEPTH};
				if (keyDown != s_r.keyState[idx]) begin
					// Lost keystrokes still update state so they are not replayed
					s_nxt.keyState[idx] = keyDown;
					if (need != 2'h0) begin
						if (!s_r.overrun && fits) begin
							s_nxt.push = 1'b1;
							s_nxt.pushData = first;
							s_nxt.second = code;
							if (need == 2'h2) begin
								adv = 1'b0;
								s_nxt.st = S_PUSH2;
							end
						end else begin
							s_nxt.overrun = 1'b1;
						end
					end
					if (keyDown && idx != pksl_pkg::KEY_PAUSE
							&& (s_r.mode != pksl_pkg::MODE_3
							|| cfg == pksl_pkg::CFG_REPEAT)) begin
						s_nxt.repArmed = 1'b1;
						s_nxt.repKey = idx;
						s_nxt.repCnt = pksl_pkg::REP_DELAY_TICKS;
					end else if (!keyDown && idx == s_r.repKey) begin
						s_nxt.repArmed = 1'b0;
					end
				end
			end
			S_PUSH2: begin
				s_nxt.push = 1'b1;
				s_nxt.pushData = s_r.second;
				adv = 1'b1;
			end
			default: begin
				s_nxt.st = S_POR;
			end
		endcase

		if (adv) begin
			if (s_r.row != 3'h7) begin
				s_nxt.row = s_r.row + 3'h1;
				s_nxt.st = S_ROW;
			end else if (s_r.col != 3'h7) begin
				s_nxt.col = s_r.col + 3'h1;
				s_nxt.colDrive = ~(8'h01 << (s_r.col + 3'h1));
				s_nxt.settle = pksl_pkg::SETTLE_CYC;
				s_nxt.st = S_SETTLE;
			end else begin
				s_nxt.colDrive = 8'hFF;
				s_nxt.st = S_IDLE;
			end
		end

		// Repeat timer runs on scan ticks; its set beats the sender's clear
		if (s_r.tickPulse && s_r.repArmed && s_r.scanning) begin
			if (s_r.repCnt == 6'h00) begin
				s_nxt.repPend = 1'b1;
				s_nxt.repCnt = pksl_pkg::REP_PERIOD_TICKS;
			end else begin
				s_nxt.repCnt = s_r.repCnt - 6'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
			s_r.st <= S_POR;
			s_r.ts <= T_IDLE;
			s_r.timer <= 23'(POR_CYC - 1);
			s_r.mode <= pksl_pkg::MODE_2;
			s_r.colDrive <= 8'hFF;
			s_r.rowMeta <= 8'hFF;
			s_r.rowSync <= 8'hFF;
			s_r.rowSnap <= 8'hFF;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign colDrive = s_r.colDrive;
	assign kbClkOut = s_r.pinLow;
	assign kbDatOut = s_r.pinLow;
	assign scanMode = s_r.mode;
	assign selfTestFail = s_r.fail;
	assign keysActive = s_r.scanning;
endmodule // pksl_top
`default_nettype wire

// ==== tb/pksl_top_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module pksl_top_checker #(
	parameter int POR_CYC = pksl_pkg::POR_CYC,
	parameter int TEST_CYC = pksl_pkg::TEST_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] colDrive,
	input wire logic kbClkIn,
	input wire logic kbClkOe,
	input wire logic kbDatIn,
	input wire logic kbDatOe,
	input wire logic modeLoad,
	input wire logic [1:0] modeSel,
	input wire logic hostCmdRcvd,
	input wire logic [1:0] scanMode,
	input wire logic selfTestFail,
	input wire logic keysActive
);
	int lowCnt_r, highCnt_r, idleCnt_r, pulseCnt_r, sinceRst_r, testCnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk) begin
		if (reset) begin
			lowCnt_r <= 0;
			highCnt_r <= 0;
			idleCnt_r <= 0;
			pulseCnt_r <= 0;
			sinceRst_r <= 0;
			testCnt_r <= 0;
		end else begin
			lowCnt_r <= kbClkOe ? lowCnt_r + 1 : 0;
			highCnt_r <= kbClkOe ? 0 : highCnt_r + 1;
			idleCnt_r <= (kbClkIn && kbDatIn) ? idleCnt_r + 1 : 0;
			sinceRst_r <= sinceRst_r + 1;
			testCnt_r <= (colDrive == 8'h00) ? testCnt_r + 1 : 0;
			// Long idle before a rise means a new frame
			if ($rose(kbClkOe)) begin
				pulseCnt_r <= (highCnt_r > 1000) ? 1 : pulseCnt_r + 1;
			end
		end
	end
	property p_resetMode;
		@(posedge clk) disable iff (1'b0)
		reset |=> scanMode == pksl_pkg::MODE_2 && !kbClkOe && !keysActive;
	endproperty
	a_resetMode: assert property (p_resetMode) else $error("bad reset state");
	property p_porDelay;
		$rose(colDrive == 8'h00) |-> sinceRst_r >= POR_CYC - 1;
	endproperty
	a_porDelay: assert property (p_porDelay) else $error("test too early");
	property p_testLen;
		$fell(colDrive == 8'h00) |->
			testCnt_r >= TEST_CYC * 3 / 4 && testCnt_r <= TEST_CYC * 5 / 4;
	endproperty
	a_testLen: assert property (p_testLen) else $error("test length");
	property p_failQuiet;
		selfTestFail || colDrive == 8'h00 |-> !keysActive;
	endproperty
	a_failQuiet: assert property (p_failQuiet) else $error("keys active");
	property p_cmdClears;
		selfTestFail && hostCmdRcvd |=> !selfTestFail;
	endproperty
	a_cmdClears: assert property (p_cmdClears) else $error("fail stuck");
	property p_modeLoad;
		modeLoad |=> scanMode == ($past(modeSel) == 2'h0 ?
			$past(scanMode) : $past(modeSel));
	endproperty
	a_modeLoad: assert property (p_modeLoad) else $error("mode load");
	property p_scanOne;
		keysActive |-> $onehot0(~colDrive);
	endproperty
	a_scanOne: assert property (p_scanOne) else $error("columns");
	property p_inhibit;
		$rose(kbDatOe) && !$past(kbClkOe) |-> idleCnt_r >= 396;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("sent inhibited");
	property p_startLow;
		$rose(kbClkOe) && highCnt_r > 1000 |-> kbDatOe;
	endproperty
	a_startLow: assert property (p_startLow) else $error("start bit");
	property p_dataHold;
		kbClkOe && $past(kbClkOe) |-> $stable(kbDatOe);
	endproperty
	a_dataHold: assert property (p_dataHold) else $error("data moved");
	property p_lowPhase;
		$fell(kbClkOe) |-> lowCnt_r >= 600 && lowCnt_r <= 1000;
	endproperty
	a_lowPhase: assert property (p_lowPhase) else $error("clock low");
	property p_highPhase;
		$rose(kbClkOe) |-> highCnt_r >= 600 && (highCnt_r <= 800 ||
			highCnt_r > 1000);
	endproperty
	a_highPhase: assert property (p_highPhase) else $error("clock high");
	property p_elevenBits;
		highCnt_r == 1000 |-> pulseCnt_r inside {0, 10, 11};
	endproperty
	a_elevenBits: assert property (p_elevenBits) else $error("bit count");
	c_frame: cover property ($rose(kbClkOe) && highCnt_r > 1000);
	c_fail: cover property ($rose(selfTestFail));
	c_mode: cover property (modeLoad && modeSel == 2'h3);
endmodule // pksl_top_checker
bind pksl_top pksl_top_checker #(.POR_CYC(POR_CYC), .TEST_CYC(TEST_CYC))
	pksl_top_checker_inst (.clk(clk), .reset(reset), .colDrive(colDrive),
	.kbClkIn(kbClkIn), .kbClkOe(kbClkOe), .kbDatIn(kbDatIn),
	.kbDatOe(kbDatOe), .modeLoad(modeLoad), .modeSel(modeSel),
	.hostCmdRcvd(hostCmdRcvd), .scanMode(scanMode),
	.selfTestFail(selfTestFail), .keysActive(keysActive));
`default_nettype wire

// ==== tb/pksl_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pksl_host_model (
	input wire logic clk,
	input wire logic clkOe,
	input wire logic datOe,
	input wire logic holdClk,
	output logic lineClk,
	output logic lineDat,
	output logic rxStrobe,
	output logic [7:0] rxByte,
	output logic rxBad
);
	logic [9:0] bitsR;
	logic [3:0] cntR;
	logic lastClk;
	int quietR;
	// Pull-ups: a released wire reads high
	assign lineClk = !(clkOe || holdClk);
	assign lineDat = !datOe;
	initial begin
		bitsR = 10'h000;
		cntR = 4'h0;
		lastClk = 1'b1;
		quietR = 0;
		rxStrobe = 1'b0;
		rxByte = 8'h00;
		rxBad = 1'b0;
	end
	// Receive only; host-to-device timing is never exercised
	always @(posedge clk) begin
		rxStrobe <= 1'b0;
		lastClk <= lineClk;
		quietR <= lineClk ? quietR + 1 : 0;
		if (quietR > 1000) begin
			cntR <= 4'h0;
		end
		if (lastClk && !lineClk && clkOe) begin
			if (cntR == 4'hA) begin
				rxByte <= bitsR[8:1];
				rxBad <= bitsR[0] || !lineDat || !(^bitsR[9:1]);
				rxStrobe <= 1'b1;
				cntR <= 4'h0;
			end else begin
				bitsR <= {lineDat, bitsR[9:1]};
				cntR <= cntR + 4'h1;
			end
		end
	end
endmodule // pksl_host_model
`default_nettype wire

// ==== tb/pksl_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module pksl_top_tb;
	logic clk, reset, kbClkIn, kbDatIn, modeLoad, hostCmdRcvd, holdClk;
	logic cfgLoad;
	logic [5:0] cfgKey;
	logic kbClkOe, kbDatOe, selfTestFail, keysActive, rxStrobe, rxBad, sent;
	logic [7:0] colDrive, rowSense, rxByte;
	logic [1:0] modeSel, scanMode, cfgVal;
	logic [63:0] keyDown;
	logic [7:0] rxQ[$];
	int error_cnt, compares;
	// Rows: {value loaded, mode expected}; zero leaves the mode alone
	logic [3:0] modeRows[4] = '{4'h5, 4'hF, 4'h3, 4'hA};
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	pksl_top #(.POR_CYC(100), .TEST_CYC(200), .SCAN_CYC(2000)) pksl_top_inst (
		.clk(clk), .reset(reset), .colDrive(colDrive), .rowSense(rowSense),
		.kbClkIn(kbClkIn), .kbClkOut(), .kbClkOe(kbClkOe), .kbDatIn(kbDatIn),
		.kbDatOut(), .kbDatOe(kbDatOe), .modeLoad(modeLoad),
		.modeSel(modeSel), .cfgLoad(cfgLoad), .cfgKey(cfgKey),
		.cfgVal(cfgVal),
		.hostCmdRcvd(hostCmdRcvd), .scanMode(scanMode),
		.selfTestFail(selfTestFail), .keysActive(keysActive));
	pksl_host_model pksl_host_model_inst (.clk(clk), .clkOe(kbClkOe),
		.datOe(kbDatOe), .holdClk(holdClk), .lineClk(kbClkIn),
		.lineDat(kbDatIn), .rxStrobe(rxStrobe), .rxByte(rxByte),
		.rxBad(rxBad));
	// Closed key pulls its row low while its column is driven
	always @(negedge clk) begin
		logic [7:0] rows;
		rows = 8'hFF;
		for (int c = 0; c < 8; c++) begin
			if (!colDrive[c]) begin
				rows = rows & ~keyDown[c * 8 +: 8];
			end
		end
		rowSense <= rows;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("Mismatches %0d of %0d compares", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic give_up(input logic ok);
		if (!ok) begin
			error_cnt++;
			$display("[ERR] %0t wait ran out", $time);
			complete_run();
		end
	endtask
	task automatic get_byte(input logic [7:0] exp);
		for (int i = 0; i < 40000 && rxQ.size() == 0; i++) begin
			tick(1);
		end
		give_up(rxQ.size() != 0);
		check(rxQ.pop_front(), exp);
	endtask
	task automatic do_reset();
		reset = 1'b1;
		tick(6);
		check({6'h00, scanMode}, {6'h00, pksl_pkg::MODE_2});
		reset = 1'b0;
	endtask
	always @(posedge clk) begin
		if (rxStrobe) begin
			rxQ.push_back(rxByte);
			check({7'h00, rxBad}, 8'h00);
		end
	end
	initial begin
		reset = 1'b1;
		modeLoad = 1'b0;
		modeSel = 2'h0;
		hostCmdRcvd = 1'b0;
		holdClk = 1'b0;
		cfgLoad = 1'b0;
		cfgKey = 6'h00;
		cfgVal = 2'h0;
		error_cnt = 0;
		compares = 0;
		// Key 5 shorted during self-test
		keyDown = 64'h20;
		do_reset();
		for (int i = 0; i < 1000 && selfTestFail !== 1'b1; i++) begin
			tick(1);
		end
		give_up(selfTestFail === 1'b1);
		check({7'h00, keysActive}, 8'h00);
		get_byte(pksl_pkg::CODE_FAIL);
		// Commands only count once the error byte has left the link
		tick(900);
		check({7'h00, keysActive}, 8'h00);
		check({7'h00, selfTestFail}, 8'h01);
		hostCmdRcvd = 1'b1;
		tick(1);
		hostCmdRcvd = 1'b0;
		tick(1);
		check({7'h00, selfTestFail}, 8'h00);
		check({7'h00, keysActive}, 8'h01);
		keyDown = 64'h0;
		do_reset();
		foreach (modeRows[i]) begin
			modeSel = modeRows[i][3:2];
			modeLoad = 1'b1;
			tick(1);
			modeLoad = 1'b0;
			tick(1);
			check({6'h00, scanMode}, {6'h00, modeRows[i][1:0]});
		end
		// Host holds the clock across the end of self-test
		holdClk = 1'b1;
		sent = 1'b0;
		repeat (800) begin
			tick(1);
			sent = sent | kbClkOe | kbDatOe;
		end
		check({7'h00, sent}, 8'h00);
		holdClk = 1'b0;
		// Short host hold inside bit 0: the frame must still complete
		for (int i = 0; i < 1000 && kbDatOe !== 1'b1; i++) begin
			tick(1);
		end
		give_up(kbDatOe === 1'b1);
		tick(100);
		holdClk = 1'b1;
		tick(200);
		holdClk = 1'b0;
		get_byte(pksl_pkg::CODE_DONE);
		// Stop bit low phase still runs after the host has the byte
		tick(900);
		check({7'h00, keysActive}, 8'h01);
		keyDown[63] = 1'b1;
		get_byte(pksl_pkg::CODE_BASE_2 + 8'h3F);
		// Set-three key config must leave set two alone
		cfgKey = 6'h09;
		cfgVal = pksl_pkg::CFG_MAKE_ONLY;
		cfgLoad = 1'b1;
		tick(1);
		cfgLoad = 1'b0;
		keyDown[63] = 1'b0;
		keyDown[9] = 1'b1;
		get_byte(pksl_pkg::CODE_BASE_2 + 8'h09);
		keyDown[9] = 1'b0;
		get_byte(pksl_pkg::CODE_BREAK_PFX);
		get_byte(pksl_pkg::CODE_BASE_2 + 8'h09);
		// A queued byte would show as a start bit well inside this span
		tick(900);
		sent = 1'b0;
		repeat (3100) begin
			tick(1);
			sent = sent | kbDatOe;
		end
		check({7'h00, sent}, 8'h00);
		check({7'h00, rxQ.size() == 0}, 8'h01);
		complete_run();
	end
endmodule // pksl_top_tb
`default_nettype wire
